// [logic/sdl_loader.sv]
// Serial input front end of a 16-bit voltage-output converter.
// Assumes chip select, serial clock, data, load and clear arrive asynchronously
// and are oversampled by clock_i; serial clock must stay well below clock_i / 4.
`timescale 1ns/1ps
`default_nettype none

module sdl_loader (
    // System
    input  wire logic                      clock_i,
    input  wire logic                      rst_i,
    // Serial pins
    input  wire logic                      sel_n_i,
    input  wire logic                      sclk_i,
    input  wire logic                      din_i,
    input  wire logic                      load_output_n_i,
    input  wire logic                      async_clear_n_i,
    // Conversion stage
    output logic [sdl_pkg::WORD_W-1:0]     dac_code_o,
    output logic                           dac_update_o
);
    import sdl_pkg::*;

    sdl_regs_t r_r;
    sdl_regs_t r_nxt;
    logic      sclk_rise;
    logic      cs_fall;
    logic      cs_rise;
    logic      clr_fall;

    // Edge finder shared by the select, serial clock and clear pins; cur is the second sync stage
    // Reading only the second stage keeps metastable values out of the logic
    function automatic logic edge_of(
        input logic cur,
        input logic old,
        input logic rising
    );
        edge_of = rising ? (cur & ~old) : (~cur & old);
    endfunction

    // Edge detectors read only the second sync stage and its history
    assign sclk_rise = edge_of(r_r.s2.sclk, r_r.prev.sclk, 1'b1);
    assign cs_fall   = edge_of(r_r.s2.csn, r_r.prev.csn, 1'b0);
    assign cs_rise   = edge_of(r_r.s2.csn, r_r.prev.csn, 1'b1);
    assign clr_fall  = edge_of(r_r.s2.clrn, r_r.prev.clrn, 1'b0);

    // Next-state logic; clear outranks every other event
    always_comb begin
        r_nxt      = r_r;
        r_nxt.s1   = '{csn: sel_n_i, sclk: sclk_i, din: din_i,
                       ldn: load_output_n_i, clrn: async_clear_n_i};
        r_nxt.s2   = r_r.s1;
        r_nxt.prev = r_r.s2;
        r_nxt.upd  = 1'b0;
        if (clr_fall) begin
            r_nxt.shift = CODE_ZERO;
            r_nxt.hold  = CODE_ZERO;
            r_nxt.upd   = 1'b1;
            r_nxt.cnt   = CNT_RESET;
            r_nxt.st    = SDL_CLEAR;
        end else begin
            case (r_r.st)
                SDL_IDLE: begin
                    if (cs_fall) begin
                        r_nxt.cnt = CNT_RESET;
                        r_nxt.st  = SDL_SHIFT;
                    end
                end
                SDL_SHIFT: begin
                    // Shift left so the first bit ends at bit 15
                    if (sclk_rise && !r_r.s2.csn && r_r.cnt != BITS_FULL) begin
                        r_nxt.shift = {r_r.shift[WORD_W-2:0], r_r.s2.din};
                        r_nxt.cnt   = r_r.cnt + 5'h01;
                    end
                    if (cs_rise) begin
                        r_nxt.st = SDL_IDLE;
                        // Short frames leave the holding register alone
                        if (r_r.cnt == BITS_FULL && !r_r.s2.ldn) begin
                            r_nxt.hold = r_r.shift;
                            r_nxt.upd  = 1'b1;
                        end
                    end
                end
                SDL_CLEAR: begin
                    // Stay here until clear is released; a new frame waits for a fresh fall
                    if (r_r.s2.clrn)
                        r_nxt.st = SDL_IDLE;
                end
                default: r_nxt.st = SDL_IDLE;
            endcase
            // Load level copies whenever clear is high and no frame is open; held low it tracks the word
            // Only a complete word may reach the holding register by load
            if (!r_r.s2.ldn && r_r.s2.clrn && r_r.st != SDL_CLEAR
                && r_r.cnt == BITS_FULL) begin
                if (r_nxt.hold != r_r.shift && !(r_r.st == SDL_SHIFT && !r_r.s2.csn)) begin
                    r_nxt.hold = r_r.shift;
                    r_nxt.upd  = 1'b1;
                end
            end
        end
    end

    // Single state register; reset gives zero code
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            // Sync stages start at idle pin levels so no false edge follows reset
            r_r <= '{st: SDL_IDLE, s1: PINS_IDLE, s2: PINS_IDLE, prev: PINS_IDLE,
                     shift: 16'h0000, cnt: 5'h00, hold: 16'h0000, upd: 1'b0};
        end else begin
            r_r <= r_nxt;
        end
    end

    assign dac_code_o   = r_r.hold;
    assign dac_update_o = r_r.upd;

    // Assertions
    chk_hold_on_clear: assert property (@(posedge clock_i) disable iff (rst_i)
        clr_fall |=> (r_r.hold == CODE_ZERO && r_r.shift == CODE_ZERO))
        else $error("clear did not zero registers");
    chk_no_load_clr: assert property (@(posedge clock_i) disable iff (rst_i)
        (!r_r.s2.clrn && !clr_fall) |=> $stable(r_r.hold))
        else $error("holding changed while clear low");
    chk_idle_stable: assert property (@(posedge clock_i) disable iff (rst_i)
        (r_r.st == SDL_IDLE && r_r.s2.csn && !clr_fall) |=> $stable(r_r.shift))
        else $error("shift changed outside frame");
    chk_short_frame: assert property (@(posedge clock_i) disable iff (rst_i)
        (cs_rise && r_r.cnt != BITS_FULL && !clr_fall) |=> $stable(r_r.hold))
        else $error("short frame transferred");
    chk_cs_transfer: assert property (@(posedge clock_i) disable iff (rst_i)
        (r_r.st == SDL_SHIFT && cs_rise && r_r.cnt == BITS_FULL && !r_r.s2.ldn && !clr_fall)
        |=> r_r.hold == $past(r_r.shift))
        else $error("full frame not transferred");
    chk_shift_bit: assert property (@(posedge clock_i) disable iff (rst_i)
        (r_r.st == SDL_SHIFT && sclk_rise && !r_r.s2.csn && r_r.cnt < BITS_FULL && !clr_fall)
        |=> r_r.shift[0] == $past(r_r.s2.din) && r_r.cnt == $past(r_r.cnt) + 5'h01)
        else $error("bit not captured");
    chk_cnt_restart: assert property (@(posedge clock_i) disable iff (rst_i)
        (r_r.st == SDL_IDLE && cs_fall && !clr_fall) |=> r_r.cnt == CNT_RESET)
        else $error("counter not restarted");
    chk_cnt_bound: assert property (@(posedge clock_i) disable iff (rst_i)
        r_r.cnt <= BITS_FULL)
        else $error("counter beyond word");
    chk_hold_cause: assert property (@(posedge clock_i) disable iff (rst_i)
        !$stable(r_r.hold) |-> r_r.upd)
        else $error("holding changed without update");
    // Update strobe lasts exactly one cycle
    chk_upd_pulse: assert property (@(posedge clock_i) disable iff (rst_i)
        r_r.upd |=> !r_r.upd)
        else $error("update strobe longer than one cycle");
    // Clear parks the sequencer until the pin is released
    chk_clear_state: assert property (@(posedge clock_i) disable iff (rst_i)
        clr_fall |=> (r_r.st == SDL_CLEAR && r_r.cnt == CNT_RESET))
        else $error("clear did not park sequencer");
    // Serial clock outside a frame never counts
    chk_idle_sclk: assert property (@(posedge clock_i) disable iff (rst_i)
        (r_r.st == SDL_IDLE && sclk_rise && !cs_fall && !clr_fall) |=> $stable(r_r.cnt))
        else $error("idle serial clock counted");
    // Level load copies a complete word while no frame is open
    chk_load_copy: assert property (@(posedge clock_i) disable iff (rst_i)
        (r_r.st == SDL_IDLE && !r_r.s2.ldn && r_r.s2.clrn && r_r.cnt == BITS_FULL
         && !clr_fall) |=> r_r.hold == $past(r_r.shift))
        else $error("load did not copy serial word");
    // Older bits move one place toward the top on each capture
    chk_msb_first: assert property (@(posedge clock_i) disable iff (rst_i)
        (r_r.st == SDL_SHIFT && sclk_rise && !r_r.s2.csn && r_r.cnt < BITS_FULL && !clr_fall)
        |=> r_r.shift[15:1] == $past(r_r.shift[14:0]))
        else $error("bits not shifted toward msb");
    // A falling select opens a frame
    chk_frame_enter: assert property (@(posedge clock_i) disable iff (rst_i)
        (r_r.st == SDL_IDLE && cs_fall && !clr_fall) |=> r_r.st == SDL_SHIFT)
        else $error("frame not opened");
    // Reset leaves the holding register at zero code
    chk_reset_zero: assert property (@(posedge clock_i)
        $fell(rst_i) |-> (r_r.hold == CODE_ZERO && !r_r.upd))
        else $error("holding not zero after reset");
    // Extra serial clocks beyond sixteen bits leave the word alone
    chk_extra_bits: assert property (@(posedge clock_i) disable iff (rst_i)
        (r_r.st == SDL_SHIFT && sclk_rise && r_r.cnt == BITS_FULL && !clr_fall)
        |=> $stable(r_r.shift))
        else $error("bit beyond word captured");
    // While clear is low nothing but a fresh fall moves the serial register
    chk_clear_shift: assert property (@(posedge clock_i) disable iff (rst_i)
        (r_r.st == SDL_CLEAR && !clr_fall) |=> $stable(r_r.shift))
        else $error("serial register moved during clear");

    // Main scenarios; a short frame and a level load are the corner cases
    cov_full_frame: cover property (@(posedge clock_i) cs_rise && r_r.cnt == BITS_FULL);
    cov_clear:      cover property (@(posedge clock_i) clr_fall);
    cov_load_pin:   cover property (@(posedge clock_i) r_r.upd && r_r.s2.csn);
    cov_short:      cover property (@(posedge clock_i) cs_rise && r_r.cnt != BITS_FULL);
    cov_clr_load:   cover property (@(posedge clock_i) !r_r.s2.clrn && !r_r.s2.ldn);
endmodule // sdl_loader

`default_nettype wire

// [pkg/sdl_pkg.sv]
// Package for the serial converter input loader: widths, reset codes, states.
// Assumes a single 40 MHz system clock samples all serial pins.
package sdl_pkg;
    localparam int unsigned WORD_W      = 16;
    localparam int unsigned CNT_W       = 5;
    localparam logic [4:0]  BITS_FULL   = 5'h10;
    localparam logic [15:0] CODE_ZERO   = 16'h0000;
    localparam logic [4:0]  CNT_RESET   = 5'h00;
    // Pin levels after reset: selects, load, clear high; clock and data low
    localparam logic [4:0]  PINS_IDLE   = 5'h13;
    localparam int unsigned CLK_HZ      = 40_000_000;
    localparam int unsigned LINK_PER_NS = 200;

    // Frame sequencer states, one-hot
    typedef enum logic [2:0] {
        SDL_IDLE  = 3'b001,
        SDL_SHIFT = 3'b010,
        SDL_CLEAR = 3'b100
    } sdl_state_t;

    // Synchronised serial pin levels
    typedef struct packed {
        logic csn;
        logic sclk;
        logic din;
        logic ldn;
        logic clrn;
    } sdl_pins_t;

    // Whole module state
    typedef struct packed {
        sdl_state_t        st;
        sdl_pins_t         s1;
        sdl_pins_t         s2;
        sdl_pins_t         prev;
        logic [15:0]       shift;
        logic [4:0]        cnt;
        logic [15:0]       hold;
        logic              upd;
    } sdl_regs_t;
endpackage

// [verif/sdl_host.sv]
// Host serial controller model: chip select, serial clock, data.
// Assumes the testbench calls its tasks one at a time.
`timescale 1ns/1ps
`default_nettype none
module sdl_host (
    // Serial pins toward the loader
    output logic sel_n_o,
    output logic sclk_o,
    output logic din_o
);
    initial begin
        sel_n_o = 1'b1;
        sclk_o  = 1'b0;
        din_o   = 1'b0;
    end
    // One frame of n bits, MSB first; clock idles low outside frames
    task automatic send(input logic [15:0] w, input int n);
        sel_n_o = 1'b0;
        #100;
        for (int i = 0; i < n; i++) begin
            din_o = w[15-i];
            #100 sclk_o = 1'b1;
            #100 sclk_o = 1'b0;
        end
        #100 sel_n_o = 1'b1;
        din_o = ~din_o; // Released line must not keep the last bit
    endtask
    // Clock and data noise with chip select high
    task automatic noise();
        for (int i = 0; i < 16; i++) begin
            din_o = i[0];
            #100 sclk_o = 1'b1;
            #100 sclk_o = 1'b0;
        end
    endtask
endmodule // sdl_host
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the serial converter loader.
// Assumes sdl_host drives the serial pins with a 200 ns link clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sdl_pkg::*;
    logic        clock_i = 1'b0;
    logic        rst_i   = 1'b1;
    logic        ld_n    = 1'b1;
    logic        clr_n   = 1'b1;
    wire logic   sel_n, sclk, din, upd;
    wire logic [15:0] code;
    int          err_count = 0;
    int          comparisons = 0;
    int          upd_seen = 0;
    always #12.5 clock_i = ~clock_i;
    // Count update strobes as the design drives them
    always @(posedge clock_i) if (upd === 1'b1) upd_seen <= upd_seen + 1;
    sdl_host i_sdl_host (.sel_n_o(sel_n), .sclk_o(sclk), .din_o(din));
    sdl_loader i_sdl_loader (.clock_i(clock_i), .rst_i(rst_i), .sel_n_i(sel_n),
        .sclk_i(sclk), .din_i(din), .load_output_n_i(ld_n), .async_clear_n_i(clr_n),
        .dac_code_o(code), .dac_update_o(upd));
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("Error %0t: code %h expected %h", $time, s, e);
        end
    endtask
    // Settle past the three-clock answer latency, then compare
    task automatic look(input logic [15:0] e);
        repeat (10) @(posedge clock_i);
        chk(code, e);
    endtask
    task automatic pins(input logic l, input logic c);
        @(posedge clock_i);
        #2 ld_n = l;
        clr_n = c;
    endtask
    task automatic final_report();
        $display("Checks %0d, errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Full frame with load low moves on chip select rise
    task automatic t_cs_load();
        pins(1'b0, 1'b1);
        i_sdl_host.send(16'hA5C3, 16);
        look(16'hA5C3);
        chk(16'(upd_seen), 16'h0001);
    endtask
    // Load high keeps word in serial register until load falls
    task automatic t_load_output_n();
        pins(1'b1, 1'b1);
        i_sdl_host.send(16'h1234, 16);
        look(16'hA5C3);
        pins(1'b0, 1'b1);
        look(16'h1234);
        chk(16'(upd_seen), 16'h0002);
        pins(1'b1, 1'b1);
    endtask
    // Short frame and idle noise leave the code alone
    task automatic t_refuse();
        i_sdl_host.send(16'hFFFF, 15);
        look(16'h1234);
        i_sdl_host.noise();
        look(16'h1234);
        chk(16'(upd_seen), 16'h0002);
    endtask
    // Clear zeroes code; load pulses ignored while clear low
    task automatic t_clear();
        pins(1'b1, 1'b0);
        look(CODE_ZERO);
        pins(1'b0, 1'b0);
        look(CODE_ZERO);
        chk(16'(upd_seen), 16'h0003);
        pins(1'b1, 1'b1);
    endtask
    initial begin
        repeat (16) @(posedge clock_i);
        #2 rst_i = 1'b0;
        repeat (8) @(posedge clock_i);
        chk(code, CODE_ZERO);
        t_cs_load();
        t_load_output_n();
        t_refuse();
        t_clear();
        final_report();
    end
    // Watchdog well beyond the few frames above
    initial begin
        #500000;
        err_count++;
        final_report();
    end
endmodule // testbench
`default_nettype wire
